// File: design/mswr_heartbeat.v
// heartbeat toggle from a cycle divider on ref_clk
// assumes ref_clk at 100 MHz; runs only while enabled
`timescale 1ns/10ps
`default_nettype none
`include "mswr_defs.vh"
module mswr_heartbeat #(
  parameter HB_CYCLES = `MSWR_HB_CYCLES
) (
  input wire ref_clk,
  input wire reset,
  input wire run,
  output reg beat
);
  reg [`MSWR_HB_W-1:0] count;
  wire at_end;
  assign at_end = (count == HB_CYCLES[`MSWR_HB_W-1:0] - 1'b1);
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= {`MSWR_HB_W{1'b0}};
      beat <= 1'b0;
    end else if (!run) begin
      count <= {`MSWR_HB_W{1'b0}};
    end else if (at_end) begin
      count <= {`MSWR_HB_W{1'b0}};
      beat <= ~beat;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // mswr_heartbeat
`default_nettype wire

// File: design/mswr_status_words.v
// motion status word reporter: builds the two status words
// assumes all event inputs are one-cycle pulses and levels
// synchronous to ref_clk, supplied by the motion core
//
// How it works
// - homing_done high only after successful homing, low otherwise
// - standstill bit high whenever motor not moving
// - immediate stop sets standstill but leaves move-finished low
// - hold bit high once running move is placed in hold
// - ccw and cw bits follow turning direction
// - enable bit shows driver enabled; current stays on at e-stop
// - current cut on driver fault, or idle with zero percent reduction
// - stall bit set when stall detected
// - ack rises on preset or error reset, falls on command clear
// - encoder error bit only on absolute-encoder variants
// - heartbeat toggles every 500 ms in command mode only
// - limit bit set at limit in move; clears on release or reset
// - bad jog change bit set on out-of-range jog parameter change
// - reserved bits 8,5,3,2 of word 1 read zero
// - driver fault high during overtemp with driver enabled
// - link loss then restore sets lost flag and input error
// - protocol-only loss does not set lost flag
// - hot bit set above 90 degrees internal
// - input bits follow inputs after configured polarity
// - above 95 degrees current removed and fault reported
// - move-finished set on clean completion, cleared by new move
// - latched errors cleared only by host error reset bit; limit bit also clears on release
// - mode bit one in configuration, zero in command mode
`timescale 1ns/10ps
`default_nettype none
`include "mswr_defs.vh"
module mswr_status_words #(
  parameter ABS_ENCODER = 1'b1,
  parameter HB_CYCLES = `MSWR_HB_CYCLES
) (
  input wire ref_clk,
  input wire reset,
  input wire config_mode,
  input wire motor_moving,
  input wire turning_clockwise,
  input wire turning_counterclockwise,
  input wire homing_ok,
  input wire homing_start,
  input wire move_ok,
  input wire move_start,
  input wire immediate_stop,
  input wire hold_entered,
  input wire hold_left,
  input wire driver_enable,
  input wire idle_zero_current,
  input wire estop_active,
  input wire stall_seen,
  input wire preset_ok,
  input wire enc_preset_ok,
  input wire error_reset_ok,
  input wire error_reset_bit,
  input wire preset_cmd_bit,
  input wire enc_preset_cmd_bit,
  input wire enc_fault,
  input wire limit_hit,
  input wire limit_active,
  input wire bad_jog_change,
  input wire [7:0] motor_temp_c,
  input wire [7:0] cpu_temp_c,
  input wire phy_link_up,
  input wire input_error_event,
  input wire in1_raw,
  input wire in2_raw,
  input wire input_one_asserted_high,
  input wire input_two_asserted_high,
  output reg [15:0] motion_status_primary,
  output reg [15:0] drive_status_secondary,
  output wire motor_current_on,
  output wire input_error
);
  wire heartbeat;
  wire homing_done;
  wire hold_flag;
  wire done_flag;
  wire stall_flag;
  wire enc_flag;
  wire limit_flag;
  wire jog_flag;
  wire lost_flag;
  wire ack_flag;
  wire input_one_asserted;
  wire input_two_asserted;
  wire overtemp;
  wire hot90;
  wire ack_set;
  wire ack_clear;
  wire link_restored;
  wire limit_released;
  reg link_was_down;
  reg phy_link_q;
  reg limit_q;
  reg ack_src_preset;
  reg ack_src_enc;
  reg ack_src_reset;
  reg [15:0] next_word0;
  reg [15:0] next_word1;

  mswr_heartbeat #(
    .HB_CYCLES(HB_CYCLES)
  ) u_heartbeat (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(~config_mode),
    .beat(heartbeat)
  );

  // homed until a new homing starts, any move starts or an immediate stop
  mswr_sticky_flag u_home (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(homing_ok),
    .clear_flag(homing_start | move_start | immediate_stop),
    .flag(homing_done)
  );

  mswr_sticky_flag u_hold (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(hold_entered),
    .clear_flag(hold_left | immediate_stop | move_start),
    .flag(hold_flag)
  );

  // done flag; immediate stop never sets it
  mswr_sticky_flag u_done (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(move_ok & ~immediate_stop),
    .clear_flag(move_start | preset_ok | error_reset_ok),
    .flag(done_flag)
  );

  mswr_sticky_flag u_stall (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(stall_seen),
    .clear_flag(error_reset_ok),
    .flag(stall_flag)
  );

  // encoder fault only with absolute encoder fitted
  mswr_sticky_flag u_enc (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(enc_fault & ABS_ENCODER[0]),
    .clear_flag(error_reset_ok),
    .flag(enc_flag)
  );

  // limit flag, cleared on release or error reset
  mswr_sticky_flag u_limit (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(limit_hit & motor_moving),
    .clear_flag(limit_released | error_reset_ok),
    .flag(limit_flag)
  );

  mswr_sticky_flag u_jog (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(bad_jog_change),
    .clear_flag(error_reset_ok),
    .flag(jog_flag)
  );

  mswr_sticky_flag u_lost (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(link_restored),
    .clear_flag(error_reset_ok),
    .flag(lost_flag)
  );

  // input error also set on restore
  mswr_sticky_flag u_inerr (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(link_restored | input_error_event |
      (limit_hit & motor_moving)),
    .clear_flag(error_reset_ok),
    .flag(input_error)
  );

  // ack until host drops the command bit
  mswr_sticky_flag u_ack (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_flag(ack_set),
    .clear_flag(ack_clear),
    .flag(ack_flag)
  );

  assign ack_set = preset_ok | enc_preset_ok | error_reset_ok;
  assign ack_clear = (ack_src_preset & ~preset_cmd_bit) |
    (ack_src_enc & ~enc_preset_cmd_bit) |
    (ack_src_reset & ~error_reset_bit);
  assign link_restored = link_was_down & phy_link_up & ~phy_link_q;
  assign limit_released = limit_q & ~limit_active;

  // remember which command the ack belongs to
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_src_preset <= 1'b0;
      ack_src_enc <= 1'b0;
      ack_src_reset <= 1'b0;
      phy_link_q <= 1'b0;
      link_was_down <= 1'b0;
      limit_q <= 1'b0;
    end else begin
      if (ack_set) begin
        ack_src_preset <= preset_ok;
        ack_src_enc <= enc_preset_ok;
        ack_src_reset <= error_reset_ok;
      end else if (ack_clear) begin
        ack_src_preset <= 1'b0;
        ack_src_enc <= 1'b0;
        ack_src_reset <= 1'b0;
      end
      phy_link_q <= phy_link_up;
      limit_q <= limit_active;
      // only a physical drop arms the restore event
      if (phy_link_q & ~phy_link_up) begin
        link_was_down <= 1'b1;
      end else if (link_restored) begin
        link_was_down <= 1'b0;
      end
    end
  end

  wire [1:0] in_raw;
  wire [1:0] in_pol;
  wire [1:0] in_asserted;
  genvar g;
  assign in_raw = {in2_raw, in1_raw};
  assign in_pol = {input_two_asserted_high, input_one_asserted_high};

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_input
      assign in_asserted[g] = in_raw[g] ~^ in_pol[g];
    end
  endgenerate
  assign input_one_asserted = in_asserted[0];
  assign input_two_asserted = in_asserted[1];

  // overtemp fault clears itself as it cools
  assign overtemp = (motor_temp_c > `MSWR_TEMP_TRIP_C) |
    (cpu_temp_c > `MSWR_TEMP_TRIP_C);
  assign hot90 = cpu_temp_c > `MSWR_TEMP_WARN_C;

  // current gating; e-stop does not cut it
  assign motor_current_on = driver_enable & ~overtemp &
    ~(~motor_moving & idle_zero_current) & (estop_active | 1'b1);

  always @* begin
    next_word0 = `MSWR_WORD_ZERO;
    next_word0[`MSWR_W0_MODE] = config_mode;
    next_word0[`MSWR_W0_INERR] = input_error;
    next_word0[`MSWR_W0_DONE] = done_flag;
    next_word0[`MSWR_W0_HOME] = homing_done;
    next_word0[`MSWR_W0_STOP] = ~motor_moving;
    next_word0[`MSWR_W0_HOLD] = hold_flag;
    next_word0[`MSWR_W0_CCW] = motor_moving & turning_counterclockwise;
    next_word0[`MSWR_W0_CW] = motor_moving & turning_clockwise;
  end

  always @* begin
    next_word1 = `MSWR_WORD_ZERO;
    next_word1[`MSWR_W1_ENA] = driver_enable;
    next_word1[`MSWR_W1_STALL] = stall_flag;
    next_word1[`MSWR_W1_ACK] = ack_flag;
    next_word1[`MSWR_W1_ABSENC] = enc_flag;
    next_word1[`MSWR_W1_HB] = heartbeat & ~config_mode;
    next_word1[`MSWR_W1_LIMIT] = limit_flag;
    next_word1[`MSWR_W1_BADJOG] = jog_flag;
    // fault shown only with driver enabled
    next_word1[`MSWR_W1_DFLT] = driver_enable & overtemp;
    next_word1[`MSWR_W1_LOST] = lost_flag;
    next_word1[`MSWR_W1_HOT90] = hot90;
    next_word1[`MSWR_W1_IN2] = input_two_asserted;
    next_word1[`MSWR_W1_IN1] = input_one_asserted;
  end

  // both words registered in the same edge
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      motion_status_primary <= `MSWR_WORD_ZERO;
      drive_status_secondary <= `MSWR_WORD_ZERO;
    end else begin
      motion_status_primary <= next_word0;
      drive_status_secondary <= next_word1;
    end
  end
endmodule // mswr_status_words
`default_nettype wire

// File: design/mswr_sticky_flag.v
// one latched status flag, set dominant over clear
// assumes ref_clk domain, set and clear synchronous
`timescale 1ns/10ps
`default_nettype none
module mswr_sticky_flag (
  input wire ref_clk,
  input wire reset,
  input wire set_flag,
  input wire clear_flag,
  output reg flag
);
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_flag) begin
      flag <= 1'b1;
    end else if (clear_flag) begin
      flag <= 1'b0;
    end
  end
endmodule // mswr_sticky_flag
`default_nettype wire

// File: pkg/mswr_defs.vh
// constants for the motion status word reporter
// assumes a 100 MHz ref_clk; included by bare name
`ifndef MSWR_DEFS_VH
`define MSWR_DEFS_VH

`define MSWR_CLK_PERIOD_NS 10
`define MSWR_HEARTBEAT_MS 500
`define MSWR_HB_CYCLES ((`MSWR_HEARTBEAT_MS * 1000000) / `MSWR_CLK_PERIOD_NS)
`define MSWR_HB_W 26
`define MSWR_TEMP_WARN_C 8'h5A
`define MSWR_TEMP_TRIP_C 8'h5F

// status word 0 bit positions
`define MSWR_W0_CW 0
`define MSWR_W0_CCW 1
`define MSWR_W0_HOLD 2
`define MSWR_W0_STOP 3
`define MSWR_W0_HOME 4
`define MSWR_W0_DONE 7
`define MSWR_W0_INERR 11
`define MSWR_W0_MODE 15

// status word 1 bit positions
`define MSWR_W1_IN1 0
`define MSWR_W1_IN2 1
`define MSWR_W1_HOT90 4
`define MSWR_W1_LOST 6
`define MSWR_W1_DFLT 7
`define MSWR_W1_BADJOG 9
`define MSWR_W1_LIMIT 10
`define MSWR_W1_HB 11
`define MSWR_W1_ABSENC 12
`define MSWR_W1_ACK 13
`define MSWR_W1_STALL 14
`define MSWR_W1_ENA 15

`define MSWR_WORD_ZERO 16'h0000

`endif

// File: tb/mswr_checker.sv
// checker: port assertions for the status word reporter
// assumes ref_clk domain with async active high reset
`timescale 1ns/10ps
`default_nettype none
module mswr_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic config_mode,
  input wire logic motor_moving,
  input wire logic turning_clockwise,
  input wire logic turning_counterclockwise,
  input wire logic stall_seen,
  input wire logic error_reset_bit,
  input wire logic preset_cmd_bit,
  input wire logic enc_preset_cmd_bit,
  input wire logic driver_enable,
  input wire logic [7:0] motor_temp_c,
  input wire logic [7:0] cpu_temp_c,
  input wire logic in1_raw,
  input wire logic in2_raw,
  input wire logic input_one_asserted_high,
  input wire logic input_two_asserted_high,
  input wire logic [15:0] motion_status_primary,
  input wire logic [15:0] drive_status_secondary,
  input wire logic motor_current_on
);
  wire [15:0] w0 = motion_status_primary;
  wire [15:0] w1 = drive_status_secondary;
  wire [1:0] dir = motor_moving ?
    {turning_counterclockwise, turning_clockwise} : 2'b00;
  wire [1:0] act = {in2_raw == input_two_asserted_high, in1_raw == input_one_asserted_high};
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_stop_bit: assert property (1 |=>
    w0[3] == !$past(motor_moving)) else $error("stop bit wrong");
  chk_dir_bits: assert property (1 |=>
    w0[1:0] == $past(dir)) else $error("direction bits wrong");
  chk_mode_bit: assert property (1 |=>
    w0[15] == $past(config_mode)) else $error("mode bit wrong");
  chk_resv_zero: assert property (
    (w1 & 16'h012C) == 16'h0000) else $error("reserved bit set");
  chk_input_bits: assert property (1 |=>
    w1[1:0] == $past(act)) else $error("input bits wrong");
  chk_hot_bit: assert property (1 |=>
    w1[4] == ($past(cpu_temp_c) > 8'h5A)) else $error("hot bit wrong");
  chk_stall_set: assert property (stall_seen |-> ##2
    w1[14]) else $error("stall flag missing");
  chk_ack_fall: assert property ($fell(error_reset_bit) &&
    !preset_cmd_bit && !enc_preset_cmd_bit |-> ##2 !w1[13])
    else $error("ack did not fall");
  chk_hot_cut: assert property (motor_temp_c > 8'h5F ##1
    motor_temp_c > 8'h5F |-> !motor_current_on)
    else $error("current on while hot");
  chk_enable_bit: assert property (1 |=>
    w1[15] == $past(driver_enable)) else $error("enable bit wrong");
  chk_fault_bit: assert property (1 |=>
    w1[7] == $past(driver_enable &&
    (motor_temp_c > 8'h5F || cpu_temp_c > 8'h5F)))
    else $error("fault bit wrong");
endmodule // mswr_checker
bind mswr_status_words mswr_checker u_chk (
  .ref_clk(ref_clk), .reset(reset), .config_mode(config_mode),
  .motor_moving(motor_moving), .turning_clockwise(turning_clockwise),
  .turning_counterclockwise(turning_counterclockwise),
  .stall_seen(stall_seen), .error_reset_bit(error_reset_bit),
  .preset_cmd_bit(preset_cmd_bit),
  .enc_preset_cmd_bit(enc_preset_cmd_bit),
  .driver_enable(driver_enable),
  .motor_temp_c(motor_temp_c), .cpu_temp_c(cpu_temp_c),
  .in1_raw(in1_raw), .in2_raw(in2_raw),
  .input_one_asserted_high(input_one_asserted_high), .input_two_asserted_high(input_two_asserted_high),
  .motion_status_primary(motion_status_primary),
  .drive_status_secondary(drive_status_secondary),
  .motor_current_on(motor_current_on)
);
`default_nettype wire

// File: tb/mswr_host.sv
// host model: samples both status words each cycle
// assumes words are coherent at every ref_clk edge
`timescale 1ns/10ps
`default_nettype none
module mswr_host (
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic [15:0] word0,
  input wire logic [15:0] word1,
  output logic [15:0] snap0,
  output logic [15:0] snap1,
  output int beats
);
  always @(posedge ref_clk) begin
    snap0 <= word0;
    snap1 <= word1;
    if (clear)
      beats <= 0;
    else if (word1[11] !== snap1[11])
      beats <= beats + 1;
  end
endmodule // mswr_host
`default_nettype wire

// File: tb/tb.sv
// testbench: random level sweep, then event scenarios
// assumes HB_CYCLES of 8 and an absolute encoder build
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, reset, config_mode, motor_moving, turning_clockwise;
  logic turning_counterclockwise, driver_enable, idle_zero_current;
  logic estop_active, limit_active, phy_link_up, in1_raw, in2_raw;
  logic input_one_asserted_high, input_two_asserted_high, clear, motor_current_on;
  logic input_error;
  logic [7:0] motor_temp_c, cpu_temp_c;
  logic [14:0] ev;
  logic [2:0] cmdb;
  logic [15:0] motion_status_primary, drive_status_secondary, s0, s1;
  int fails, n_tests, beats, i, k;
  int ix[3] = '{7, 10, 12};
  wire stall_seen = ev[0], enc_fault = ev[1], bad_jog_change = ev[2];
  wire homing_ok = ev[3], move_ok = ev[4], hold_entered = ev[5];
  wire limit_hit = ev[6], error_reset_ok = ev[7], immediate_stop = ev[8];
  wire move_start = ev[9], preset_ok = ev[10], hold_left = ev[11];
  wire enc_preset_ok = ev[12], homing_start = ev[13];
  wire input_error_event = ev[14];
  wire error_reset_bit = cmdb[0], preset_cmd_bit = cmdb[1];
  wire enc_preset_cmd_bit = cmdb[2];
  mswr_status_words #(.HB_CYCLES(8)) u_mswr_status_words (.*);
  mswr_host u_mswr_host (.ref_clk(ref_clk), .clear(clear),
    .word0(motion_status_primary), .word1(drive_status_secondary),
    .snap0(s0), .snap1(s1), .beats(beats));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic fire(input int i, w, b, input logic e);
    ev[i] = 1'b1;
    cyc(1);
    ev = '0;
    cyc(1);
    chk($sformatf("word%0d bit %0d", w, b), {15'h0000, e}, {15'h0000,
      w ? drive_status_secondary[b] : motion_status_primary[b]});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  initial begin
    {config_mode, motor_moving, turning_clockwise, limit_active} = '0;
    {driver_enable, idle_zero_current, estop_active, clear} = '0;
    {in1_raw, in2_raw, input_one_asserted_high, input_two_asserted_high} = '0;
    {turning_counterclockwise, ev, cmdb} = '0;
    phy_link_up = 1'b1;
    motor_temp_c = 8'h19;
    cpu_temp_c = 8'h19;
    fails = 0;
    n_tests = 0;
    reset = 1'b1;
    void'($urandom(30));
    cyc(16);
    reset = 1'b0;
    for (i = 0; i < 200; i++) begin
      {config_mode, motor_moving, turning_clockwise, in1_raw, in2_raw,
        input_one_asserted_high, input_two_asserted_high} = 7'($urandom);
      turning_counterclockwise = ~turning_clockwise;
      cpu_temp_c = 8'h50 + 8'($urandom % 16);
      cyc(1);
      chk("word0 levels", {config_mode, 11'h000, !motor_moving, 1'b0,
        motor_moving & turning_counterclockwise,
        motor_moving & turning_clockwise},
        motion_status_primary & 16'h800B);
      chk("word1 levels", {11'h000, cpu_temp_c > 8'h5A, 2'b00,
        in2_raw == input_two_asserted_high, in1_raw == input_one_asserted_high},
        drive_status_secondary & 16'h013F);
    end
    $display("level sweep done");
    {config_mode, motor_moving, turning_clockwise} = 3'b011;
    turning_counterclockwise = 1'b0;
    limit_active = 1'b1;
    fire(6, 1, 10, 1);
    limit_active = 1'b0;
    cyc(2);
    chk("limit", 16'h0000, drive_status_secondary & 16'h0400);
    fire(0, 1, 14, 1);
    fire(1, 1, 12, 1);
    fire(2, 1, 9, 1);
    fire(13, 0, 4, 0);
    fire(3, 0, 4, 1);
    fire(9, 0, 4, 0);
    fire(4, 0, 7, 1);
    fire(9, 0, 7, 0);
    fire(5, 0, 2, 1);
    fire(11, 0, 2, 0);
    motor_moving = 1'b0;
    fire(8, 0, 7, 0);
    chk("stopped", 16'h0008, motion_status_primary & 16'h0008);
    $display("event flags done");
    for (k = 0; k < 3; k++) begin
      cmdb[k] = 1'b1;
      fire(ix[k], 1, 13, 1);
      cmdb = '0;
      cyc(2);
      chk("ack", 16'h0000, drive_status_secondary & 16'h2000);
    end
    chk("stall", 16'h0000, drive_status_secondary & 16'h4000);
    phy_link_up = 1'b0;
    cyc(3);
    phy_link_up = 1'b1;
    cyc(3);
    chk("link", 16'h0040, drive_status_secondary & 16'h0040);
    chk("in error", 16'h0001, {15'h0000, input_error});
    fire(7, 1, 6, 0);
    fire(14, 0, 11, 1);
    $display("ack and link done");
    {driver_enable, estop_active} = 2'b11;
    motor_temp_c = 8'h60;
    cyc(3);
    chk("fault", 16'h0080, drive_status_secondary & 16'h0080);
    chk("current", 16'h0000, {15'h0000, motor_current_on});
    motor_temp_c = 8'h19;
    cyc(3);
    chk("enable", 16'h8000, drive_status_secondary & 16'h8080);
    chk("current", 16'h0001, {15'h0000, motor_current_on});
    chk("host snap0", motion_status_primary, s0);
    chk("host snap1", drive_status_secondary & 16'hF7FF,
      s1 & 16'hF7FF);
    idle_zero_current = 1'b1;
    cyc(3);
    chk("current", 16'h0000, {15'h0000, motor_current_on});
    $display("drive current done");
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(80);
    chk("beats", 16'h000A, 16'(beats));
    config_mode = 1'b1;
    cyc(4);
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(80);
    chk("beats cfg", 16'h0000,
      16'(beats) | (drive_status_secondary & 16'h0800));
    $display("heartbeat done");
    wrap_up;
  end
endmodule // tb
`default_nettype wire
